// ===== acs_map.vh
// register map, field positions, reset values and timing counts of the converter sequencer
`ifndef ACS_MAP_VH
`define ACS_MAP_VH

// ========================================================
// register indices (byte address is four times the index)
`define ACS_IDX_CTRL_ONE     6'h00
`define ACS_IDX_CTRL_TWO     6'h01
`define ACS_IDX_MAX_CONV     6'h02
`define ACS_IDX_CHSEL_FIRST  6'h03
`define ACS_IDX_CHSEL_LAST   6'h06
`define ACS_IDX_SEQ_STAT     6'h07
`define ACS_IDX_RESULT_FIRST 6'h08
`define ACS_IDX_RESULT_LAST  6'h17
`define ACS_IDX_CTRL_THREE   6'h18
`define ACS_IDX_STATUS       6'h19
`define ACS_IDX_RSVD_FIRST   6'h1c
`define ACS_IDX_RSVD_LAST    6'h1f

// ========================================================
// control one fields
`define ACS_C1_CASCADE       4
`define ACS_C1_START_STOP    5
`define ACS_C1_ROUTE_A       6
`define ACS_C1_ROUTE_B       7
`define ACS_C1_ACQ_LO        8
// control two fields (sequencer 2 sits eight bits higher)
`define ACS_C2_SW_START      0
`define ACS_C2_EV_EN         1
`define ACS_C2_EVERY_OTHER   2
`define ACS_C2_SEQ_RESET     3
`define ACS_C2_INT_EN        4
`define ACS_C2_SEQ2_OFS      8
// control three fields
`define ACS_C3_CLKPS_LO      0
`define ACS_C3_EXT_REF       8
// status fields
`define ACS_ST_ACTIVE_LO     0
`define ACS_ST_FLAG_LO       2
`define ACS_ST_PHASE_LO      4
`define ACS_ST_CONV_BUSY     6

// ========================================================
// reset values
`define ACS_CTRL_ONE_RST     16'h0000
`define ACS_CTRL_TWO_RST     16'h0000
`define ACS_MAX_CONV_RST     16'h0000
`define ACS_CHSEL_RST        16'h0000

// ========================================================
// timing
`define ACS_SYS_CLK_MHZ      250
`define ACS_ADC_CLK_MHZ      25
`define ACS_CONV_TIME_NS     80
`define ACS_CONV_TICKS       (`ACS_CONV_TIME_NS * `ACS_ADC_CLK_MHZ / 1000)
`define ACS_CLKPS_RST        (`ACS_SYS_CLK_MHZ / `ACS_ADC_CLK_MHZ - 1)
`define ACS_FULL_SCALE       12'hfff

// ========================================================
// bus answers
`define ACS_RESP_OKAY        2'b00
`define ACS_RESP_SLVERR      2'b10

`endif

// ===== acs_autoseq.v
// converter autosequencer: two 8-slot or one 16-slot sequencer, one shared core, AXI4-Lite registers
//
// How it works
// [RQ1] up to sixteen slots, each picks any channel its sequencer may use
// [RQ2] two 8-slot sequencers or one cascaded 16-slot
// [RQ3] dual: own eight channels; cascaded: all sixteen
// [RQ4] each slot result lands in own register
// [RQ5] same channel allowed in many slots
// [RQ6] twelve-bit results saturate at zero and 4095
// [RQ7] start by software, event manager a or b
// [RQ8] interrupt on every or every second end
// [RQ9] start/stop mode resumes pointer on next trigger
// [RQ10] dual mode: a and b start independently
// [RQ11] acquisition window has its own prescale
// [RQ12] one core serves both sequencers in turn
// [RQ13] conversion is 80 ns at 25 MHz
// [RQ14] registers on system clock, timing on peripheral clock
// [RQ15] reset: gate low, registers reset, analog off
// [RQ16] gate high enables registers and analog section
// [RQ17] software waits milliseconds before first conversion
// [RQ18] halt powers analog down, registers keep contents
// [RQ19] software sets external reference bit at power-up
// [RQ20] start pulses routable to pins shared with trips
// [RQ21] registers contiguous, word indexed from base
// [RQ22] busy sequencer ignores triggers, ends at max count
// [RQ23] end flag sticky, every-other toggles a phase bit
`timescale 1ns/1ps
`default_nettype none
`include "acs_map.vh"

module acs_autoseq (
	input  wire        aclk,
	input  wire        aresetn,
	// power control
	input  wire        converter_clock_gate,
	input  wire        halt,
	// AXI4-Lite slave
	input  wire [7:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	input  wire [7:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready,
	// triggers
	input  wire        event_manager_a_soc,
	input  wire        event_manager_b_soc,
	// converter core
	output reg         analog_power_r,
	output reg         ext_ref_sel_r,
	output reg  [3:0]  conv_chan_r,
	output reg         conv_sample_r,
	output reg         conv_start_r,
	input  wire [13:0] core_code,
	// interrupt requests per sequencer
	output reg         seq1_irq_r,
	output reg         seq2_irq_r,
	// start pins shared with timer trips
	output reg         ext_convert_start_a_o_r,
	output reg         ext_convert_start_a_oe_r,
	input  wire        ext_convert_start_a_i,
	output reg         ext_convert_start_b_o_r,
	output reg         ext_convert_start_b_oe_r,
	input  wire        ext_convert_start_b_i,
	output reg         timer2_compare_trip_r,
	output reg         timer4_compare_trip_r
);

	// ========================================================
	// converter states
	localparam [1:0] CS_IDLE  = 2'd0;
	localparam [1:0] CS_ACQ   = 2'd1;
	localparam [1:0] CS_CONV  = 2'd2;
	localparam [1:0] CS_STORE = 2'd3;
	// full-width copies so the narrowing below is deliberate
	localparam [31:0] CONV_LAST_FULL = `ACS_CONV_TICKS - 1;
	localparam [31:0] CLKPS_RST_FULL = `ACS_CLKPS_RST;
	localparam [3:0]  CONV_LAST      = CONV_LAST_FULL[3:0];

	reg [15:0] ctrl_one_r;
	reg [15:0] ctrl_two_r;
	reg [15:0] max_conv_r;
	reg [15:0] ctrl_three_r;
	reg [15:0] chsel_r [0:3];
	reg [11:0] result_r [0:15];
	reg [1:0]  active_r;
	reg [1:0]  flag_r;
	reg [1:0]  phase_r;
	reg [3:0]  ptr1_r;
	reg [3:0]  ptr2_r;
	reg [3:0]  cnt1_r;
	reg [3:0]  cnt2_r;
	reg [1:0]  cstate_r;
	reg        owner_r;
	reg [3:0]  tick_cnt_r;
	reg [3:0]  div_cnt_r;
	reg [11:0] code_r;
	reg        aw_full_r;
	reg        w_full_r;
	reg [7:0]  aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0]  w_strb_r;
	reg [31:0] rd_data;
	reg        rd_err;
	reg        wr_err;
	reg [11:0] sat_code;
	integer    i;

	// registers and sequencing only clock while gated on and not halted
	wire run_en = converter_clock_gate & ~halt; // [RQ16] [RQ18]
	wire wr_fire = aw_full_r & w_full_r & ~s_axi_bvalid;
	wire wr_go = wr_fire & run_en & ~wr_err;
	wire [5:0] wr_idx = aw_addr_r[7:2];
	wire [15:0] wr_val = {w_strb_r[1] ? w_data_r[15:8] : 8'h00, w_strb_r[0] ? w_data_r[7:0] : 8'h00};
	wire [15:0] wr_keep = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
	wire wr_c2 = wr_go & (wr_idx == `ACS_IDX_CTRL_TWO);
	wire cascade = ctrl_one_r[`ACS_C1_CASCADE]; // [RQ2]
	wire [3:0] clkps = ctrl_three_r[`ACS_C3_CLKPS_LO +: 4];
	wire [3:0] acq_ps = ctrl_one_r[`ACS_C1_ACQ_LO +: 4];
	wire tick = (div_cnt_r == clkps);

	// ========================================================
	// start sources, software starts pulse straight from the write
	wire sw1 = wr_c2 & w_strb_r[0] & w_data_r[`ACS_C2_SW_START];
	wire sw2 = wr_c2 & w_strb_r[1] & w_data_r[`ACS_C2_SEQ2_OFS + `ACS_C2_SW_START];
	wire rst1 = wr_c2 & w_strb_r[0] & w_data_r[`ACS_C2_SEQ_RESET];
	wire rst2 = wr_c2 & w_strb_r[1] & w_data_r[`ACS_C2_SEQ2_OFS + `ACS_C2_SEQ_RESET];
	wire eva_go = ctrl_two_r[`ACS_C2_EV_EN] & event_manager_a_soc;
	wire evb_go = ctrl_two_r[`ACS_C2_SEQ2_OFS + `ACS_C2_EV_EN] & event_manager_b_soc;
	wire trig1 = sw1 | eva_go | (cascade & evb_go); // [RQ7]
	wire trig2 = ~cascade & (sw2 | evb_go); // [RQ10]

	// ========================================================
	// slot and channel of the conversion about to run
	wire [3:0] slot = owner_r ? ptr2_r : ptr1_r;
	wire [3:0] sel_nib = chsel_r[slot[3:2]][{slot[1:0], 2'b00} +: 4]; // [RQ1] [RQ5]
	wire [3:0] chan = cascade ? sel_nib : {slot[3], sel_nib[2:0]}; // [RQ3]
	wire [3:0] max1 = cascade ? max_conv_r[3:0] : {1'b0, max_conv_r[2:0]};
	wire [3:0] max2 = {1'b0, max_conv_r[6:4]};
	wire end1 = (cnt1_r == max1);
	wire end2 = (cnt2_r == max2);
	// wrap inside the sequencer's own half, or all sixteen slots when cascaded
	wire [3:0] ptr1_inc = cascade ? ptr1_r + 4'd1 : {1'b0, ptr1_r[2:0] + 3'd1};
	wire [3:0] ptr2_inc = {1'b1, ptr2_r[2:0] + 3'd1};
	wire stop_mode = ctrl_one_r[`ACS_C1_START_STOP];
	wire every1 = ctrl_two_r[`ACS_C2_EVERY_OTHER];
	wire every2 = ctrl_two_r[`ACS_C2_SEQ2_OFS + `ACS_C2_EVERY_OTHER];

	// saturate the core's signed raw code to twelve bits
	always @* begin
		if (core_code[13] || core_code == 14'h0000) begin
			sat_code = 12'h000; // [RQ6]
		end else if (core_code >= {2'b00, `ACS_FULL_SCALE}) begin
			sat_code = `ACS_FULL_SCALE; // [RQ6]
		end else begin
			sat_code = core_code[11:0];
		end
	end

	// write decode: anything outside the map is refused
	always @* begin
		wr_err = 1'b0;
		if (aw_addr_r[1:0] != 2'b00 || aw_addr_r[7:2] > `ACS_IDX_RSVD_LAST) begin
			wr_err = 1'b1;
		end else if (aw_addr_r[7:2] > `ACS_IDX_STATUS && aw_addr_r[7:2] < `ACS_IDX_RSVD_FIRST) begin
			wr_err = 1'b1;
		end
	end

	// read decode, narrow registers sit in the low bits
	always @* begin
		rd_data = 32'h0000_0000;
		rd_err = 1'b0;
		if (s_axi_araddr[1:0] != 2'b00) begin
			rd_err = 1'b1;
		end else begin
			case (s_axi_araddr[7:2]) // [RQ21]
				`ACS_IDX_CTRL_ONE:   rd_data[15:0] = ctrl_one_r;
				`ACS_IDX_CTRL_TWO:   rd_data[15:0] = ctrl_two_r;
				`ACS_IDX_MAX_CONV:   rd_data[15:0] = max_conv_r;
				`ACS_IDX_SEQ_STAT:   rd_data[15:0] = {cnt2_r, cnt1_r, ptr2_r, ptr1_r};
				`ACS_IDX_CTRL_THREE: rd_data[15:0] = ctrl_three_r;
				`ACS_IDX_STATUS:     rd_data[6:0] = {cstate_r != CS_IDLE, phase_r, flag_r, active_r};
				default: begin
					if (s_axi_araddr[7:2] >= `ACS_IDX_CHSEL_FIRST && s_axi_araddr[7:2] <= `ACS_IDX_CHSEL_LAST) begin
						rd_data[15:0] = chsel_r[s_axi_araddr[3:2] + 2'd1];
					end else if (s_axi_araddr[7:2] >= `ACS_IDX_RESULT_FIRST
						&& s_axi_araddr[7:2] <= `ACS_IDX_RESULT_LAST) begin
						// results start eight words up: flipping index bit 3 maps 0x08..0x17 to 0..15
						rd_data[11:0] = result_r[{~s_axi_araddr[5], s_axi_araddr[4:2]}]; // [RQ4]
					end else if (s_axi_araddr[7:2] < `ACS_IDX_RSVD_FIRST
						|| s_axi_araddr[7:2] > `ACS_IDX_RSVD_LAST) begin
						rd_err = 1'b1;
					end
				end
			endcase
		end
	end

	// ========================================================
	// AXI4-Lite handshakes: address and data caught in either order
	always @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `ACS_RESP_OKAY;
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rresp <= `ACS_RESP_OKAY;
			s_axi_rdata <= 32'h0000_0000;
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= 32'h0000_0000;
			w_strb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			// a stopped register clock drops the write but still answers
			if (wr_fire) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wr_err ? `ACS_RESP_SLVERR : `ACS_RESP_OKAY;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= rd_data;
				s_axi_rresp <= rd_err ? `ACS_RESP_SLVERR : `ACS_RESP_OKAY;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// ========================================================
	// converter clock divider, held at zero while the peripheral clock is stopped
	always @(posedge aclk) begin
		if (!aresetn || !run_en || tick) begin
			div_cnt_r <= 4'h0; // [RQ14]
		end else begin
			div_cnt_r <= div_cnt_r + 4'd1;
		end
	end

	// ========================================================
	// registers, sequencers and the shared converter
	always @(posedge aclk) begin
		if (!aresetn) begin
			// register clock still runs in reset so every default is reached
			ctrl_one_r <= `ACS_CTRL_ONE_RST; // [RQ15]
			ctrl_two_r <= `ACS_CTRL_TWO_RST;
			max_conv_r <= `ACS_MAX_CONV_RST;
			ctrl_three_r <= CLKPS_RST_FULL[15:0];
			for (i = 0; i < 4; i = i + 1) begin
				chsel_r[i] <= `ACS_CHSEL_RST;
			end
			for (i = 0; i < 16; i = i + 1) begin
				result_r[i] <= 12'h000;
			end
			active_r <= 2'b00;
			flag_r <= 2'b00;
			phase_r <= 2'b00;
			ptr1_r <= 4'h0;
			ptr2_r <= 4'h8;
			cnt1_r <= 4'h0;
			cnt2_r <= 4'h0;
			cstate_r <= CS_IDLE;
			owner_r <= 1'b0;
			tick_cnt_r <= 4'h0;
			code_r <= 12'h000;
			conv_chan_r <= 4'h0;
			conv_sample_r <= 1'b0;
			conv_start_r <= 1'b0;
		end else if (run_en) begin
			conv_start_r <= 1'b0;
			// register writes; start and reset bits act once and never store
			if (wr_go) begin
				case (wr_idx)
					`ACS_IDX_CTRL_ONE:   ctrl_one_r <= (ctrl_one_r & ~wr_keep) | wr_val;
					`ACS_IDX_CTRL_TWO:   ctrl_two_r <= ((ctrl_two_r & ~wr_keep) | wr_val) & 16'h1616;
					`ACS_IDX_MAX_CONV:   max_conv_r <= (max_conv_r & ~wr_keep) | wr_val;
					`ACS_IDX_CTRL_THREE: ctrl_three_r <= (ctrl_three_r & ~wr_keep) | wr_val;
					`ACS_IDX_STATUS:     flag_r <= flag_r & ~wr_val[`ACS_ST_FLAG_LO +: 2];
					default: begin
						if (wr_idx >= `ACS_IDX_CHSEL_FIRST && wr_idx <= `ACS_IDX_CHSEL_LAST) begin
							chsel_r[wr_idx[1:0] + 2'd1] <= (chsel_r[wr_idx[1:0] + 2'd1] & ~wr_keep) | wr_val;
						end
					end
				endcase
			end
			// a trigger during a live session is ignored
			if (trig1 && !active_r[0]) begin
				active_r[0] <= 1'b1; // [RQ22]
				cnt1_r <= 4'h0;
			end
			if (trig2 && !active_r[1]) begin
				active_r[1] <= 1'b1; // [RQ22]
				cnt2_r <= 4'h0;
			end
			if (rst1) begin
				active_r[0] <= 1'b0;
				ptr1_r <= 4'h0;
				cnt1_r <= 4'h0;
			end
			if (rst2) begin
				active_r[1] <= 1'b0;
				ptr2_r <= 4'h8;
				cnt2_r <= 4'h0;
			end
			case (cstate_r)
				CS_IDLE: begin
					// sequencer 1 first; each grant runs one slot, and sequencer 2 is granted only while sequencer 1 is idle
					if (active_r[0] || (active_r[1] && !cascade)) begin
						owner_r <= ~active_r[0]; // [RQ12]
						cstate_r <= CS_ACQ;
						tick_cnt_r <= 4'h0;
					end
				end
				CS_ACQ: begin
					conv_chan_r <= chan;
					conv_sample_r <= 1'b1;
					if (tick) begin
						tick_cnt_r <= tick_cnt_r + 4'd1;
						if (tick_cnt_r == acq_ps) begin
							cstate_r <= CS_CONV; // [RQ11]
							tick_cnt_r <= 4'h0;
							conv_sample_r <= 1'b0;
							conv_start_r <= 1'b1;
						end
					end
				end
				CS_CONV: begin
					if (tick) begin
						tick_cnt_r <= tick_cnt_r + 4'd1;
						if (tick_cnt_r == CONV_LAST) begin
							cstate_r <= CS_STORE; // [RQ13]
							code_r <= sat_code;
						end
					end
				end
				CS_STORE: begin
					result_r[slot] <= code_r; // [RQ4]
					cstate_r <= CS_IDLE;
					if (!owner_r) begin
						cnt1_r <= cnt1_r + 4'd1;
						ptr1_r <= ptr1_inc;
						if (end1) begin
							active_r[0] <= 1'b0; // [RQ22]
							phase_r[0] <= ~phase_r[0]; // [RQ23]
							if (!stop_mode) begin
								ptr1_r <= 4'h0; // [RQ9]
							end
							if (!every1 || phase_r[0]) begin
								flag_r[0] <= 1'b1; // [RQ8] [RQ23]
							end
						end
					end else begin
						cnt2_r <= cnt2_r + 4'd1;
						ptr2_r <= ptr2_inc;
						if (end2) begin
							active_r[1] <= 1'b0; // [RQ22]
							phase_r[1] <= ~phase_r[1]; // [RQ23]
							if (!stop_mode) begin
								ptr2_r <= 4'h8; // [RQ9]
							end
							if (!every2 || phase_r[1]) begin
								flag_r[1] <= 1'b1; // [RQ8] [RQ23]
							end
						end
					end
				end
				default: cstate_r <= CS_IDLE;
			endcase
		end else begin
			// a stopped clock must not stretch the start strobe
			conv_start_r <= 1'b0;
		end
	end

	// ========================================================
	// power, reference select, interrupt requests and pin sharing
	always @(posedge aclk) begin
		if (!aresetn) begin
			analog_power_r <= 1'b0; // [RQ15]
			ext_ref_sel_r <= 1'b0;
			seq1_irq_r <= 1'b0;
			seq2_irq_r <= 1'b0;
			ext_convert_start_a_o_r <= 1'b0;
			ext_convert_start_a_oe_r <= 1'b0;
			ext_convert_start_b_o_r <= 1'b0;
			ext_convert_start_b_oe_r <= 1'b0;
			timer2_compare_trip_r <= 1'b0;
			timer4_compare_trip_r <= 1'b0;
		end else begin
			analog_power_r <= run_en; // [RQ16] [RQ18]
			ext_ref_sel_r <= ctrl_three_r[`ACS_C3_EXT_REF];
			seq1_irq_r <= flag_r[0] & ctrl_two_r[`ACS_C2_INT_EN]; // [RQ8]
			seq2_irq_r <= flag_r[1] & ctrl_two_r[`ACS_C2_SEQ2_OFS + `ACS_C2_INT_EN];
			// a routed pin drives the start pulse, otherwise it feeds the trip input
			ext_convert_start_a_oe_r <= ctrl_one_r[`ACS_C1_ROUTE_A]; // [RQ20]
			ext_convert_start_a_o_r <= ctrl_one_r[`ACS_C1_ROUTE_A] & event_manager_a_soc;
			timer2_compare_trip_r <= ~ctrl_one_r[`ACS_C1_ROUTE_A] & ext_convert_start_a_i;
			ext_convert_start_b_oe_r <= ctrl_one_r[`ACS_C1_ROUTE_B]; // [RQ20]
			ext_convert_start_b_o_r <= ctrl_one_r[`ACS_C1_ROUTE_B] & event_manager_b_soc;
			timer4_compare_trip_r <= ~ctrl_one_r[`ACS_C1_ROUTE_B] & ext_convert_start_b_i;
		end
	end

endmodule

`default_nettype wire

// ===== acs_core_model.sv
// converter core stand-in returning a code that depends on the selected channel
`timescale 1ns/1ps
`default_nettype none
// ========================================
// core model
module acs_core_model (
	input  wire logic        aclk,
	input  wire logic        analog_power_r,
	input  wire logic [3:0]  conv_chan_r,
	output logic      [13:0] core_code
);
	logic [13:0] flip_r = 14'h2aaa;
	// unpowered core shows a toggling pattern, so a stale code can never look valid
	always @(posedge aclk) begin
		flip_r <= ~flip_r;
	end
	// channel 0 is below ground, 15 above full scale, others mid range
	assign core_code = !analog_power_r ? flip_r :
		(conv_chan_r == 4'h0) ? 14'h3ffb :
		(conv_chan_r == 4'hf) ? 14'h1388 : {4'h0, conv_chan_r, 6'h07};
endmodule
`default_nettype wire

// ===== acs_autoseq_asserts.sv
// port assertions for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
// ========================================
// checker
module acs_autoseq_asserts (
	input wire        aclk,
	input wire        aresetn,
	input wire        converter_clock_gate,
	input wire        halt,
	input wire        s_axi_awvalid,
	input wire        s_axi_awready,
	input wire        s_axi_wvalid,
	input wire        s_axi_wready,
	input wire        s_axi_bvalid,
	input wire        s_axi_bready,
	input wire [1:0]  s_axi_bresp,
	input wire        s_axi_arvalid,
	input wire        s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire        s_axi_rvalid,
	input wire        s_axi_rready,
	input wire        analog_power_r,
	input wire        conv_sample_r,
	input wire        conv_start_r,
	input wire        ext_convert_start_a_oe_r,
	input wire        timer2_compare_trip_r
);
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	// bus answers and their holding
	// a joint take is caught on one edge and answered on the next
	a_b_after_take: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
		else $error("write answer missing");
	a_r_after_take: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
		else $error("read answer missing");
	a_b_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write answer dropped");
	a_r_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped");
	a_one_outstanding: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write ready while answer pending");
	a_one_read: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read ready while answer pending");
	// power follows gate and halt one cycle late; the guard skips the first edge after reset
	a_power_follows: assert property ($past(aresetn) |-> analog_power_r == $past(converter_clock_gate && !halt))
		else $error("analog power wrong");
	// start is a single pulse and never overlaps acquisition
	a_start_pulse: assert property (conv_start_r |=> !conv_start_r)
		else $error("start pulse too long");
	a_start_no_sample: assert property (conv_start_r |-> !conv_sample_r && analog_power_r)
		else $error("start during acquisition");
	a_trip_masked: assert property ($past(ext_convert_start_a_oe_r) && ext_convert_start_a_oe_r |-> !timer2_compare_trip_r)
		else $error("trip passed while routed");
	c_write: cover property (s_axi_bvalid && s_axi_bready);
	c_start: cover property (conv_start_r);
	c_routed: cover property (ext_convert_start_a_oe_r);
endmodule
bind acs_autoseq acs_autoseq_asserts i_acs_autoseq_asserts (.aclk(aclk), .aresetn(aresetn),
	.converter_clock_gate(converter_clock_gate), .halt(halt), .s_axi_awvalid(s_axi_awvalid),
	.s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
	.s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .analog_power_r(analog_power_r),
	.conv_sample_r(conv_sample_r), .conv_start_r(conv_start_r),
	.ext_convert_start_a_oe_r(ext_convert_start_a_oe_r), .timer2_compare_trip_r(timer2_compare_trip_r));
`default_nettype wire

// ===== tb_top.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`default_nettype none
// ========================================
// bench
module tb_top;
	logic aclk = 1'b0, aresetn = 1'b0, gate = 1'b0, halt = 1'b0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, rv;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, pwr, ext_ref, irq1, oe_a, oe_b, trip2, trip4;
	logic soc_a = 1'b0, soc_b = 1'b0, pin_a = 1'b0;
	logic [1:0] bresp, rresp, rsp;
	logic [3:0] chan;
	logic [13:0] code;
	int n_mismatch = 0, total_checks = 0;
	always #2 aclk = ~aclk;
	acs_core_model i_acs_core_model (.aclk(aclk), .analog_power_r(pwr), .conv_chan_r(chan), .core_code(code));
	acs_autoseq i_acs_autoseq (.aclk(aclk), .aresetn(aresetn), .converter_clock_gate(gate), .halt(halt),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .event_manager_a_soc(soc_a), .event_manager_b_soc(soc_b),
		.analog_power_r(pwr), .ext_ref_sel_r(ext_ref), .conv_chan_r(chan), .conv_sample_r(),
		.conv_start_r(), .core_code(code), .seq1_irq_r(irq1), .seq2_irq_r(),
		.ext_convert_start_a_o_r(), .ext_convert_start_a_oe_r(oe_a), .ext_convert_start_a_i(pin_a),
		.ext_convert_start_b_o_r(), .ext_convert_start_b_oe_r(oe_b), .ext_convert_start_b_i(1'b0),
		.timer2_compare_trip_r(trip2), .timer4_compare_trip_r(trip4));
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	// write: both channels offered together, each dropped at its own ready; answer taken at bvalid
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rsp = bresp;
		bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rv = rdata;
		rsp = rresp;
		rready <= 1'b0;
	endtask
	task automatic pulse(input bit b);
		@(posedge aclk);
		if (b) soc_b <= 1'b1; else soc_a <= 1'b1;
		@(posedge aclk);
		soc_a <= 1'b0;
		soc_b <= 1'b0;
	endtask
	// poll status until both sequencers are idle; bounded by the watchdog as well
	task automatic wait_idle;
		int n;
		n = 0;
		do begin
			rd(8'h64);
			n++;
		end while (rv[1:0] !== 2'b00 && n < 400);
		chk(rv[1:0], 2'b00);
	endtask
	function automatic logic [31:0] code_of(input int ch);
		if (ch == 0) return 32'h0;
		if (ch == 15) return 32'hfff;
		return 32'(ch * 64 + 7);
	endfunction
	// ========================================
	// scenarios
	task automatic t_reset_gate;
		chk(pwr, 1'b0);
		rd(8'h60);
		chk(rv, 32'h9);
		wr(8'h00, 32'h10);
		rd(8'h00);
		chk(rv, 32'h0);
		gate <= 1'b1;
		repeat (50) @(posedge aclk);
		chk(pwr, 1'b1);
		rd(8'h68);
		chk(rsp, 2'b10);
		rd(8'h02);
		chk(rsp, 2'b10);
		rd(8'h70);
		chk(rv, 32'h0);
		chk(rsp, 2'b00);
		wr(8'h60, 32'h109);
		repeat (2) @(posedge aclk);
		chk(ext_ref, 1'b1);
	endtask
	task automatic t_dual_sw;
		wr(8'h0c, 32'h0033);
		wr(8'h08, 32'h0002);
		wr(8'h04, 32'h0011);
		wait_idle();
		rd(8'h20);
		chk(rv, code_of(3));
		rd(8'h24);
		chk(rv, code_of(3));
		rd(8'h28);
		chk(rv, code_of(0));
		rd(8'h2c);
		chk(rv, 32'h0);
		chk(irq1, 1'b1);
		wr(8'h64, 32'h0c);
		repeat (3) @(posedge aclk);
		chk(irq1, 1'b0);
	endtask
	task automatic t_every_other;
		logic f1;
		wr(8'h04, 32'h0017);
		wait_idle();
		f1 = rv[2];
		wr(8'h64, 32'h0c);
		pulse(1'b0);
		wait_idle();
		// one plain end came before, so the first every-other end flags and the second does not
		chk(f1, 1'b1);
		chk(rv[2], 1'b0);
		chk(rv[4], 1'b1);
		wr(8'h64, 32'h0c);
	endtask
	task automatic t_seq2_ev;
		wr(8'h04, 32'h0000);
		wr(8'h14, 32'h0005);
		wr(8'h04, 32'h0200);
		pulse(1'b1);
		wait_idle();
		rd(8'h40);
		chk(rv, code_of(13));
		rd(8'h20);
		chk(rv, code_of(3));
	endtask
	// start/stop: pointer carries on between sessions until a sequencer reset
	task automatic t_start_stop;
		wr(8'h00, 32'h20);
		wr(8'h04, 32'h0001);
		wait_idle();
		rd(8'h1c);
		chk(rv[3:0], 4'h3);
		wr(8'h04, 32'h0001);
		wait_idle();
		rd(8'h1c);
		chk(rv[3:0], 4'h6);
		wr(8'h04, 32'h0008);
		rd(8'h1c);
		chk(rv[3:0], 4'h0);
	endtask
	task automatic t_cascade;
		wr(8'h00, 32'h10);
		wr(8'h08, 32'h000f);
		wr(8'h0c, 32'hcdef);
		wr(8'h10, 32'h89ab);
		wr(8'h14, 32'h4567);
		wr(8'h18, 32'h0123);
		wr(8'h04, 32'h0001);
		wait_idle();
		for (int n = 0; n < 16; n++) begin
			rd(8'(8'h20 + 4 * n));
			chk(rv, code_of(15 - n));
		end
	endtask
	task automatic t_pins_halt;
		pin_a <= 1'b1;
		wr(8'h00, 32'hc0);
		repeat (2) @(posedge aclk);
		chk({oe_a, oe_b, trip2}, 3'b110);
		wr(8'h00, 32'h00);
		repeat (2) @(posedge aclk);
		chk({oe_a, trip2, trip4}, 3'b010);
		halt <= 1'b1;
		wr(8'h00, 32'h10);
		chk(pwr, 1'b0);
		rd(8'h00);
		chk(rv, 32'h0);
		rd(8'h20);
		chk(rv, 32'hfff);
		halt <= 1'b0;
	endtask
	task automatic close_out;
		$display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
		if (n_mismatch == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// a full run needs well under two thousand cycles; the limit leaves wide margin
	initial begin
		repeat (40000) @(posedge aclk);
		n_mismatch++;
		close_out();
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset_gate();
		t_dual_sw();
		t_every_other();
		t_seq2_ev();
		t_start_stop();
		t_cascade();
		t_pins_halt();
		close_out();
	end
endmodule
`default_nettype wire
